/* File: logic/diag_digital_mux.v */
/*
  diagnostic digital multiplexer with a classic wishbone register slave.
  routes one internal digital signal to the diagnostic output pin.
  assumes all signal inputs are synchronous to clk_i and that the pin
  driver outside turns the output enable into tri-state.
*/
// Register access over Wishbone and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "diag_mux_consts.vh"

// Summary of operation
// - digital mux selects a source only when mode field equals digital code; other modes drive 0
// - group 0 channel 1 gives inverted analog supply undervoltage
// - group 0 channels 2 and 3 give the two reference error flags
// - group 0 channel 4 pump12 undervoltage inverted, channel 5 its overvoltage
// - group 0 channel 6 gives pump17 overvoltage
// - group 0 channels 7 to 14: regulator uv/ov pairs, pre, can, io, core
// - group 0 channel 15 gives the clock loss flag
// - group 1 channels 1,3..8 give clocks and time references
// - group 1 channel 9 gives the error or trigger input level
// - group 1 channel 14 repeats the error or trigger input
// - group 1 channels 10 to 12 give chip select, serial in, serial clock
// - group 1 channel 13 gives serial output pin readback
// - group 1 channel 15 gives reset output pin readback
// - channel 0 of each group is 0; test channels carry test inputs
// - group 2 channel 3 pump overvoltage, channel 4 pump undervoltage inverted
// - group 2 channels 5 and 6 give pump phase one and two
// - group 2 channel 7 gives pump headroom flag
// - group 2 channels 9 to 15: battery uv/ov, overtemp and current limits
// - enable bit clear tri-states the pin regardless of mode and select
// - group 3 carries sensor and digital supply monitors; group 7 test modes
module diag_digital_mux #(
  parameter ADR_WIDTH = `ADR_W
) (
  input  wire                 clk_i,
  input  wire                 rst_i,
  // wishbone classic slave
  input  wire                 cyc_i,
  input  wire                 stb_i,
  input  wire                 we_i,
  input  wire [ADR_WIDTH-1:0] adr_i,
  input  wire [3:0]           sel_i,
  input  wire [31:0]          dat_i,
  output reg  [31:0]          dat_o,
  output reg                  ack_o,
  // group 0 sources
  input  wire                 analog_supply_undervoltage,
  input  wire                 reference_error_one,
  input  wire                 reference_error_two,
  input  wire                 pump12_undervoltage,
  input  wire                 pump12_overvoltage,
  input  wire                 pump17_overvoltage,
  input  wire                 prereg_undervoltage,
  input  wire                 prereg_overvoltage,
  input  wire                 can_supply_undervoltage,
  input  wire                 can_supply_overvoltage,
  input  wire                 io_supply_undervoltage,
  input  wire                 io_supply_overvoltage,
  input  wire                 core_supply_undervoltage,
  input  wire                 core_supply_overvoltage,
  input  wire                 clock_loss_flag,
  // group 1 sources
  input  wire                 system_clock_tap,
  input  wire                 watchdog_clock_tap,
  input  wire                 reset_stretch_oscillator,
  input  wire [3:0]           time_reference_taps,
  input  wire                 error_or_trigger_input,
  input  wire                 chip_select_pin_level,
  input  wire                 serial_in_pin_level,
  input  wire                 serial_clock_pin_level,
  input  wire                 serial_out_readback,
  input  wire                 reset_pin_readback,
  // group 2 sources
  input  wire [3:0]           production_test_signal,
  input  wire                 pump_overvoltage,
  input  wire                 pump_undervoltage,
  input  wire                 pump_phase_one,
  input  wire                 pump_phase_two,
  input  wire                 pump_headroom_flag,
  input  wire                 battery_undervoltage,
  input  wire                 battery_overvoltage,
  input  wire                 can_supply_overtemp,
  input  wire                 io_supply_overtemp,
  input  wire                 sensor_supply_overtemp,
  input  wire                 can_supply_current_limit,
  input  wire                 io_supply_current_limit,
  // group 3 and 7 sources
  input  wire                 sensor_current_limit,
  input  wire                 sensor_undervoltage,
  input  wire                 sensor_overvoltage,
  input  wire                 digital_supply_undervoltage,
  input  wire                 digital_supply_overvoltage,
  input  wire                 sensor_supply_tracking,
  input  wire                 monitor_trim_error,
  input  wire                 test_mode_flag,
  // diagnostic pin
  output reg                  diagnostic_output_pin_o,
  output reg                  diagnostic_output_pin_oe_o
);

  reg  [7:0]  diagnostic_config_control;
  reg  [7:0]  diag_select_value;
  reg         next_pin;
  reg         next_oe;
  wire [1:0]  diag_mode_field;
  wire [2:0]  grp;
  wire [3:0]  ch;
  wire        bus_req;
  wire        wr_cfg;
  wire        wr_sel;
  wire [15:0] grp0;
  wire [15:0] grp1;
  wire [15:0] grp2;
  wire [15:0] grp3;
  wire [15:0] grp7;

  assign diag_mode_field = diagnostic_config_control[`CFG_MODE_HI:`CFG_MODE_LO];
  assign grp     = diag_select_value[`SEL_GRP_HI:`SEL_GRP_LO];
  assign ch      = diag_select_value[`SEL_CH_HI:`SEL_CH_LO];
  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign wr_cfg  = bus_req & we_i & sel_i[0] & (adr_i == `CFG_CTRL_OFS);
  assign wr_sel  = bus_req & we_i & sel_i[0] & (adr_i == `SELECT_OFS);

  // channel maps; undervoltage comparators shown active-low (high = fine), overvoltage active-high
  assign grp0 = {clock_loss_flag,
                 core_supply_overvoltage, ~core_supply_undervoltage,
                 io_supply_overvoltage,   ~io_supply_undervoltage,
                 can_supply_overvoltage,  ~can_supply_undervoltage,
                 prereg_overvoltage,      ~prereg_undervoltage,
                 pump17_overvoltage,
                 pump12_overvoltage, ~pump12_undervoltage,
                 reference_error_two, reference_error_one,
                 ~analog_supply_undervoltage,
                 1'b0};
  assign grp1 = {reset_pin_readback,
                 error_or_trigger_input,
                 serial_out_readback,
                 serial_clock_pin_level, serial_in_pin_level,
                 chip_select_pin_level,
                 error_or_trigger_input,
                 time_reference_taps,
                 reset_stretch_oscillator, watchdog_clock_tap,
                 production_test_signal[0],
                 system_clock_tap,
                 1'b0};
  assign grp2 = {io_supply_current_limit, can_supply_current_limit,
                 sensor_supply_overtemp, io_supply_overtemp, can_supply_overtemp,
                 battery_overvoltage, ~battery_undervoltage,
                 production_test_signal[3],
                 pump_headroom_flag,
                 pump_phase_two, pump_phase_one,
                 ~pump_undervoltage, pump_overvoltage,
                 production_test_signal[2], production_test_signal[1],
                 1'b0};
  // reserved slots in group 3 read as 0
  assign grp3 = {7'h00, monitor_trim_error, sensor_supply_tracking,
                 1'b0, digital_supply_overvoltage, ~digital_supply_undervoltage,
                 sensor_overvoltage, ~sensor_undervoltage, sensor_current_limit,
                 1'b0};
  assign grp7 = {{14{production_test_signal[0]}}, test_mode_flag, 1'b0};

  always @* begin
    next_oe  = diagnostic_config_control[`CFG_ENABLE_BIT];
    next_pin = 1'b0;
    if (diag_mode_field == `MODE_DIGITAL) begin
      case (grp)
        `GRP_SUPPLY: next_pin = grp0[ch];
        `GRP_CLOCKS: next_pin = grp1[ch];
        `GRP_PUMP:   next_pin = grp2[ch];
        `GRP_SENSOR: next_pin = grp3[ch];
        `GRP_TEST:   next_pin = grp7[ch];
        default:     next_pin = 1'b0;
      endcase
    end
  end

  // the pin is registered so a select change cannot glitch it;
  // costs one cycle of latency on every sampled source
  always @(posedge clk_i) begin
    if (rst_i) begin
      diagnostic_output_pin_o    <= 1'b0;
      diagnostic_output_pin_oe_o <= 1'b0;
    end else begin
      diagnostic_output_pin_o    <= next_pin & next_oe;
      diagnostic_output_pin_oe_o <= next_oe;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      diagnostic_config_control <= `CFG_RESET;
      diag_select_value         <= `SEL_RESET;
      ack_o                     <= 1'b0;
      dat_o                     <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      dat_o <= 32'h0000_0000;
      if (wr_cfg) begin
        diagnostic_config_control <= dat_i[7:0];
      end
      if (wr_sel) begin
        diag_select_value <= dat_i[7:0] & `SEL_MASK;
      end
      if (bus_req & ~we_i) begin
        case (adr_i)
          `CFG_CTRL_OFS: dat_o <= {24'h000000, diagnostic_config_control};
          `SELECT_OFS:   dat_o <= {24'h000000, diag_select_value};
          `STATUS_OFS:   dat_o <= {30'h00000000, diagnostic_output_pin_oe_o,
                                   diagnostic_output_pin_o};
          default:       dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

/* File: logic/diag_mux_consts.vh */
/*
  constants for the diagnostic digital multiplexer: register offsets,
  field positions, reset values and mux codes.
  assumes inclusion by its bare name from the design file.
*/
`ifndef DIAG_MUX_CONSTS_VH
`define DIAG_MUX_CONSTS_VH

// byte offsets on the wishbone bus
`define CFG_CTRL_OFS      4'h0
`define SELECT_OFS        4'h4
`define STATUS_OFS        4'h8
`define ADR_W             4

// config control fields
`define CFG_MODE_LO       0
`define CFG_MODE_HI       1
`define CFG_ENABLE_BIT    7
`define CFG_RESET         8'h00

// mode field codes
`define MODE_DIGITAL      2'h1

// select value fields
`define SEL_CH_LO         0
`define SEL_CH_HI         3
`define SEL_GRP_LO        4
`define SEL_GRP_HI        6
`define SEL_RESET         8'h00
`define SEL_MASK          8'h7f

// group codes
`define GRP_SUPPLY        3'h0
`define GRP_CLOCKS        3'h1
`define GRP_PUMP          3'h2
`define GRP_SENSOR        3'h3
`define GRP_TEST          3'h7

`define CH_COUNT          16

`endif

/* File: bench/diag_digital_mux_monitor.sv */
/* bus and pin assertions for the diagnostic digital mux.
   assumes it is bound to the mux top and sees only its ports. */
`timescale 1ns/1ps
module diag_digital_mux_monitor #(
  parameter ADR_WIDTH = 4
) (
  input logic                 clk_i,
  input logic                 rst_i,
  input logic                 cyc_i,
  input logic                 stb_i,
  input logic                 we_i,
  input logic [ADR_WIDTH-1:0] adr_i,
  input logic [3:0]           sel_i,
  input logic [31:0]          dat_i,
  input logic [31:0]          dat_o,
  input logic                 ack_o,
  input logic                 diagnostic_output_pin_o,
  input logic                 diagnostic_output_pin_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_pulse;
    ack_o ##1 !ack_o;
  endsequence
  AST_ACK_PULSE: assert property (s_req |=> s_pulse)
    else $error("ack not a single pulse one cycle after request");
  AST_NO_SPURIOUS: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data not zero outside ack");
  AST_DAT_UPPER: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  AST_UNMAPPED: assert property (ack_o && !we_i && adr_i == 'hc |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_PIN_OFF: assert property (!diagnostic_output_pin_oe_o |-> !diagnostic_output_pin_o)
    else $error("pin high while not driven");
  AST_OE_RISE: assert property ($rose(diagnostic_output_pin_oe_o) |-> $past(ack_o) && $past(we_i))
    else $error("output enable rose without a write");
  AST_OFF_WRITE: assert property (ack_o && we_i && adr_i == 'h0 && sel_i[0] && !dat_i[7]
    |=> ##1 !diagnostic_output_pin_oe_o [*2])
    else $error("pin still driven after disable");
  AST_STATUS: assert property (ack_o && !we_i && adr_i == 'h8
    |-> dat_o[1:0] == {$past(diagnostic_output_pin_oe_o), $past(diagnostic_output_pin_o)})
    else $error("status does not match pin");
endmodule

/* File: bench/diag_gpio_model.sv */
/* host gpio input that reads the diagnostic pin.
   assumes no pull resistor on the pin, so a released pin floats. */
`timescale 1ns/1ps
module diag_gpio_model (
  input  logic pin_i,
  input  logic oe_i,
  output logic level_o
);
  logic last;
  // floating pin shows the inverse of its last level so a stale value never passes
  always @(pin_i or oe_i) if (oe_i) last = pin_i;
  assign level_o = oe_i ? pin_i : ~last;
endmodule

/* File: bench/diag_digital_mux_bench.sv */
/* self-checking bench for the diagnostic digital mux: wishbone tasks and map sweep.
   assumes the gpio model and the monitor are compiled before this file. */
`timescale 1ns/1ps
module diag_digital_mux_bench;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, pin, oe, level;
  logic [3:0]  adr_i, sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [51:0] src, hot;
  int          miscompares, tests_run, e;
  diag_digital_mux u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .analog_supply_undervoltage(src[0]), .reference_error_one(src[1]),
    .reference_error_two(src[2]), .pump12_undervoltage(src[3]), .pump12_overvoltage(src[4]),
    .pump17_overvoltage(src[5]), .prereg_undervoltage(src[6]), .prereg_overvoltage(src[7]),
    .can_supply_undervoltage(src[8]), .can_supply_overvoltage(src[9]),
    .io_supply_undervoltage(src[10]), .io_supply_overvoltage(src[11]),
    .core_supply_undervoltage(src[12]), .core_supply_overvoltage(src[13]),
    .clock_loss_flag(src[14]), .system_clock_tap(src[15]), .watchdog_clock_tap(src[16]),
    .reset_stretch_oscillator(src[17]), .time_reference_taps(src[21:18]),
    .error_or_trigger_input(src[22]), .chip_select_pin_level(src[23]),
    .serial_in_pin_level(src[24]), .serial_clock_pin_level(src[25]),
    .serial_out_readback(src[26]), .reset_pin_readback(src[27]),
    .production_test_signal(src[31:28]), .pump_overvoltage(src[32]),
    .pump_undervoltage(src[33]), .pump_phase_one(src[34]), .pump_phase_two(src[35]),
    .pump_headroom_flag(src[36]), .battery_undervoltage(src[37]),
    .battery_overvoltage(src[38]), .can_supply_overtemp(src[39]),
    .io_supply_overtemp(src[40]), .sensor_supply_overtemp(src[41]),
    .can_supply_current_limit(src[42]), .io_supply_current_limit(src[43]),
    .sensor_current_limit(src[44]), .sensor_undervoltage(src[45]),
    .sensor_overvoltage(src[46]), .digital_supply_undervoltage(src[47]),
    .digital_supply_overvoltage(src[48]), .sensor_supply_tracking(src[49]),
    .monitor_trim_error(src[50]), .test_mode_flag(src[51]),
    .diagnostic_output_pin_o(pin), .diagnostic_output_pin_oe_o(oe));
  diag_gpio_model u_gpio (.pin_i(pin), .oe_i(oe), .level_o(level));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // master waits for ack with no assumed latency; the bound only guards a hang
  task automatic wb(input logic w, input logic [3:0] a, s, input logic [31:0] d);
    int n;
    n = 0;
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk_i);
    if (n == 50) chk(1'b0, 1'b1);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wb(1'b1, a, 4'hf, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    wb(1'b0, a, 4'hf, 32'h0);
    chk(q, x);
  endtask
  task automatic pin_is(input logic [51:0] v, input logic x);
    src <= v;
    repeat (3) @(posedge clk_i);
    chk(level, x);
  endtask
  // -1 constant zero, -2 test channel left unchecked, else source index plus 64 if inverted
  function automatic int map(input logic [6:0] s);
    int c;
    c = s[3:0];
    case (s[6:4])
      3'h0: return c == 0 ? -1 : c == 1 ? 64 : c < 4 ? c - 1 : c == 4 ? 67 : c < 7 ? c - 1 :
                   c == 15 ? 14 : c - 1 + 64 * (c % 2);
      3'h1: return c == 0 ? -1 : c == 1 ? 15 : c == 2 ? -2 : c == 9 || c == 14 ? 22 :
                   c == 13 ? 26 : c == 15 ? 27 : c + 13;
      3'h2: return c == 0 ? -1 : c < 3 || c == 8 ? -2 : c == 3 ? 32 : c == 4 ? 97 :
                   c < 8 ? c + 29 : c == 9 ? 101 : c + 28;
      3'h3: return c == 1 ? 44 : c == 2 ? 109 : c == 3 ? 46 : c == 4 ? 111 : c == 5 ? 48 :
                   c == 7 ? 49 : c == 8 ? 50 : -1;
      3'h7: return c == 0 ? -1 : c == 1 ? 51 : -2;
      default: return -1;
    endcase
  endfunction
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    results();
  end
  initial begin
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, src} = '0;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    rd(4'h8, 32'h0);
    wr(4'h4, 32'hff);
    rd(4'h4, 32'h7f);
    rd(4'hc, 32'h0);
    $display("test registers done");
    wr(4'h0, 32'h81);
    for (int s = 0; s < 128; s++) begin
      e = map(s[6:0]);
      wr(4'h4, 32'(s));
      hot = (e < 0) ? '1 : 52'h1 << (e % 64);
      if (e != -2) begin
        pin_is(hot, e >= 0 && e < 64);
        pin_is('0, e >= 64);
        pin_is(~hot, e >= 64);
      end
    end
    $display("test map done");
    wr(4'h4, 32'h02);
    for (int m = 0; m < 4; m++) begin
      wr(4'h0, 32'h80 | 32'(m));
      pin_is('1, m == 1);
    end
    rd(4'h8, 32'h2);
    wb(1'b1, 4'h4, 4'he, 32'h11);
    rd(4'h4, 32'h02);
    wr(4'h0, 32'h01);
    // a released pin floats at the host, so the driven value itself is checked
    src <= '1;
    repeat (3) @(posedge clk_i);
    chk(pin, 1'b0);
    chk(oe, 1'b0);
    rd(4'h0, 32'h01);
    $display("test modes done");
    results();
  end
endmodule
bind diag_digital_mux diag_digital_mux_monitor #(.ADR_WIDTH(ADR_WIDTH)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .diagnostic_output_pin_o(diagnostic_output_pin_o),
  .diagnostic_output_pin_oe_o(diagnostic_output_pin_oe_o));
